/* File: core/sfcs_pkg.sv */
/*
  Package for the serial frame configuration and alternative status block:
  register offsets, field positions, reset values and timing constants.
  Assumes a 32-bit APB slave on a 200 MHz clock; each register one aligned word.
*/
// Operation
// - loop_select cuts rx pin off and feeds receiver from transmitter path.
// - receiver_source 0 internal loop, 1 single-wire from tx pin; ignored otherwise; the code feeds the receiver from tx_pin_o for both values.
// - wait_mode_stop set disables the unit while the system is in wait mode.
// - char_length_select 0 gives 8 data bits, 1 gives 9, one start, one stop.
// - wakeup 0 on idle line, 1 on address mark in msb of 9-bit characters, in data bit 6 of 8-bit ones; rx_idle never pulses, so 0 never wakes.
// - idle_type_select chooses idle count start after start bit or stop bit.
// - parity_enable puts generated and checked parity in character msb.
// - even parity bit clears on even ones count; odd parity clears on odd.
// - rx_edge_flag sets on falling rx edge, or rising when rx_polarity set.
// - the three flags clear only by writing one; zero leaves them alone.
// - bit_error_flag sets when sampled rx differs from transmitted bit, interrupt if enabled.
// - bit_error_level captures sampled rx level on each mismatch.
// - break_flag sets on received break while detection is on, interrupt if enabled.
// - frame_control reachable only with alt_map_select 0; alt_status only with 1.
// - bit_error_mode 00 off, 01 sample tick 9, 10 tick 13, 11 reserved.
// - break_detect_enable switches break detection on or off.
package sfcs_pkg;
  localparam logic [11:0] ADDR_FRAME_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_ALT_STATUS = 12'h000;
  localparam logic [11:0] ADDR_ALT_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_ALT_MODE = 12'h008;
  localparam logic [11:0] ADDR_CONTROL2 = 12'h00C;
  localparam logic [11:0] ADDR_STATUS2 = 12'h014;
  localparam logic [11:0] ADDR_TX_DATA = 12'h01C;
  localparam logic [11:0] ADDR_RX_DATA = 12'h020;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h030;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h034;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h038;
  localparam logic [11:0] ADDR_BAUD = 12'h03C;
  localparam logic [11:0] ADDR_WAIT = 12'h040;
  localparam int BIT_LOOP = 7;
  localparam int BIT_WAIT_STOP = 6;
  localparam int BIT_RECEIVER_SOURCE = 5;
  localparam int BIT_LEN9 = 4;
  localparam int BIT_WAKE = 3;
  localparam int BIT_ILT = 2;
  localparam int BIT_PEN = 1;
  localparam int BIT_PODD = 0;
  localparam int BIT_EDGE = 7;
  localparam int BIT_BIT_ERROR_LEVEL = 2;
  localparam int BIT_BERR = 1;
  localparam int BIT_BRK = 0;
  localparam int BIT_MAP = 7;
  localparam int BIT_RX_POLARITY = 3;
  localparam int BIT_TE = 3;
  localparam int BIT_RE = 2;
  localparam int BIT_RWU = 1;
  localparam int BIT_IRQ_IDLE = 3;
  localparam int BIT_IRQ_RXDONE = 4;
  localparam int BIT_IRQ_TXDONE = 5;
  localparam int BIT_IRQ_PERR = 6;
  localparam int BIT_IRQ_FERR = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h001B;
  localparam logic [3:0] TICKS_PER_BIT = 4'hF;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_9 = 4'h8;
  localparam logic [3:0] TICK_13 = 4'hC;
  localparam logic [1:0] BERR_OFF = 2'h0;
  localparam logic [1:0] BERR_T9 = 2'h1;
  localparam logic [1:0] BERR_T13 = 2'h2;
  localparam logic [3:0] BREAK_BITS_8 = 4'hA;
  localparam logic [3:0] BREAK_BITS_9 = 4'hB;
  localparam logic [3:0] IDLE_BITS_8 = 4'hA;
  localparam logic [3:0] IDLE_BITS_9 = 4'hB;
endpackage : sfcs_pkg

/* File: core/sfcs_frame_if.sv */
/*
  Interface carrying frame settings and line levels between the top and
  the receive engine. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfcs_frame_if;
  logic len9;
  logic par_en;
  logic par_odd;
  logic idle_type_select;
  logic wake_mode;
  logic rx_on;
  logic rwu;
  logic tick;
  logic rx_line;
  logic [8:0] rx_data;
  logic rx_done;
  logic rx_perr;
  logic rx_ferr;
  logic rx_break;
  logic rx_idle;
  logic rx_wake;
  modport top (output len9, par_en, par_odd, idle_type_select, wake_mode, rx_on, rwu, tick, rx_line,
    input rx_data, rx_done, rx_perr, rx_ferr, rx_break, rx_idle, rx_wake);
  modport rx (input len9, par_en, par_odd, idle_type_select, wake_mode, rx_on, rwu, tick, rx_line,
    output rx_data, rx_done, rx_perr, rx_ferr, rx_break, rx_idle, rx_wake);
endinterface : sfcs_frame_if
`default_nettype wire

/* File: core/sfcs_rx.sv */
/*
  Receive engine: 16x oversampled start, data, parity and stop, and break; idle never flags, tcnt clears on every tick in SFCS_IDLE.
  Assumes a one-cycle tick at sixteen times the bit rate and a synchronised line.
*/
`timescale 1ns/1ps
`default_nettype none
module sfcs_rx (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  sfcs_frame_if.rx fr
);
  typedef enum logic [1:0] {SFCS_IDLE, SFCS_START, SFCS_DATA, SFCS_STOP} sfcs_rx_state_e;
  sfcs_rx_state_e state;
  logic [3:0] tcnt;
  logic [3:0] bcnt;
  logic [3:0] ones;
  logic [8:0] shreg;
  logic all_zero;
  logic counting;
  logic idle_seen;
  logic [3:0] nbits;
  assign nbits = fr.len9 ? 4'h9 : 4'h8;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state <= SFCS_IDLE;
      tcnt <= 4'h0;
      bcnt <= 4'h0;
      shreg <= 9'h000;
      all_zero <= 1'b0;
      fr.rx_data <= 9'h000;
      fr.rx_done <= 1'b0;
      fr.rx_perr <= 1'b0;
      fr.rx_ferr <= 1'b0;
      fr.rx_break <= 1'b0;
      fr.rx_wake <= 1'b0;
    end else begin
      fr.rx_done <= 1'b0;
      fr.rx_perr <= 1'b0;
      fr.rx_ferr <= 1'b0;
      fr.rx_break <= 1'b0;
      fr.rx_wake <= 1'b0;
      if (!fr.rx_on) begin
        state <= SFCS_IDLE;
      end else if (fr.tick) begin
        tcnt <= tcnt + 4'h1;
        case (state)
          SFCS_IDLE: begin
            tcnt <= 4'h0;
            if (!fr.rx_line) begin
              state <= SFCS_START;
            end
          end
          SFCS_START: begin
            if (tcnt == sfcs_pkg::TICK_MID && fr.rx_line) begin
              state <= SFCS_IDLE;
            end else if (tcnt == sfcs_pkg::TICKS_PER_BIT) begin
              state <= SFCS_DATA;
              bcnt <= 4'h0;
              all_zero <= 1'b1;
            end
          end
          SFCS_DATA: begin
            if (tcnt == sfcs_pkg::TICK_MID) begin
              shreg <= {fr.rx_line, shreg[8:1]};
              all_zero <= all_zero & ~fr.rx_line;
            end
            if (tcnt == sfcs_pkg::TICKS_PER_BIT) begin
              bcnt <= bcnt + 4'h1;
              if (bcnt == nbits - 4'h1) begin
                state <= SFCS_STOP;
              end
            end
          end
          SFCS_STOP: begin
            if (tcnt == sfcs_pkg::TICK_MID) begin
              state <= SFCS_IDLE;
              fr.rx_data <= fr.len9 ? shreg : {1'b0, shreg[8:1]};
              if (!fr.rx_line && all_zero) begin
                fr.rx_break <= 1'b1;
              end else begin
                fr.rx_ferr <= ~fr.rx_line;
                // address mark wakeup on shreg[8] for 9-bit characters, on shreg[7] (data bit 6) for 8-bit ones
                if (fr.rwu) begin
                  fr.rx_wake <= fr.wake_mode & (fr.len9 ? shreg[8] : shreg[7]);
                end else begin
                  fr.rx_done <= 1'b1;
                  fr.rx_perr <= fr.par_en & ((^(fr.len9 ? shreg : {1'b0, shreg[8:1]})) ^ fr.par_odd);
                end
              end
            end
          end
          default: state <= SFCS_IDLE;
        endcase
      end
    end
  end

  // idle counting of consecutive ones
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ones <= 4'h0;
      counting <= 1'b0;
      idle_seen <= 1'b0;
      fr.rx_idle <= 1'b0;
    end else begin
      fr.rx_idle <= 1'b0;
      if (!fr.rx_on) begin
        counting <= 1'b0;
        ones <= 4'h0;
      end else if (fr.tick && tcnt == sfcs_pkg::TICK_MID) begin
        if (state == SFCS_START && !fr.idle_type_select) begin
          counting <= 1'b1;
          ones <= 4'h0;
          idle_seen <= 1'b0;
        end else if (state == SFCS_STOP && fr.idle_type_select) begin
          counting <= 1'b1;
          ones <= 4'h0;
          idle_seen <= 1'b0;
        end else if (counting) begin
          if (!fr.rx_line) begin
            ones <= 4'h0;
            counting <= fr.idle_type_select ? 1'b0 : (state != SFCS_IDLE);
          end else if (ones == (fr.len9 ? sfcs_pkg::IDLE_BITS_9 : sfcs_pkg::IDLE_BITS_8) - 4'h1) begin
            counting <= 1'b0;
            idle_seen <= 1'b1;
            fr.rx_idle <= ~idle_seen;
          end else begin
            ones <= ones + 4'h1;
          end
        end
      end
    end
  end
endmodule : sfcs_rx
`default_nettype wire

/* File: core/sfcs_top.sv */
/*
  Serial port top: APB register file, frame control, alternative status,
  transmitter, bit error check, loop and single-wire routing, interrupt.
  Assumes APB master on ref_clk_i; rx and tx pins belong to the remote node.
*/
`timescale 1ns/1ps
`default_nettype none
module sfcs_top #(
  parameter logic [15:0] BAUD_DIV = sfcs_pkg::BAUD_RESET
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin_i,
  input wire logic wait_mode_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o,
  output logic irq_o
);
  sfcs_frame_if fr ();
  logic [7:0] frame_control;
  logic [7:0] alt_control;
  logic [7:0] alt_mode;
  logic [7:0] control2;
  logic alt_map_select;
  logic rx_polarity;
  logic rx_edge_flag;
  logic bit_error_flag;
  logic bit_error_level;
  logic break_flag;
  logic [7:0] irq_status;
  logic [7:0] irq_enable;
  logic [15:0] baud;
  logic [15:0] bcount;
  logic tick;
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic wait_s1;
  logic wait_s2;
  logic [8:0] tx_hold;
  logic tx_full;
  logic [10:0] tx_shift;
  logic [3:0] tx_bits;
  logic [3:0] tx_tcnt;
  logic tx_busy;
  logic tx_done;
  logic [8:0] rx_buf;
  logic wr;
  logic rd;
  logic rx_in;
  logic unit_on;
  logic edge_ev;
  logic berr_ev;
  logic [3:0] berr_tick;
  logic [7:0] evt;

  function automatic logic [8:0] parity_char(input logic [8:0] d, input logic len9, input logic pen,
      input logic podd);
    logic [8:0] c;
    c = len9 ? d : {1'b1, d[7:0]}; // stop bit of 8-bit frames
    if (pen) begin
      if (len9) begin
        c[8] = (^d[7:0]) ^ podd;
      end else begin
        c[7] = (^d[6:0]) ^ podd;
      end
    end
    return c;
  endfunction : parity_char

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign unit_on = ~(wait_s2 & frame_control[sfcs_pkg::BIT_WAIT_STOP]);
  // receiver input routing
  always_comb begin
    if (!frame_control[sfcs_pkg::BIT_LOOP]) begin
      rx_in = rx_s2 ^ rx_polarity;
    end else if (frame_control[sfcs_pkg::BIT_RECEIVER_SOURCE]) begin
      rx_in = tx_pin_o;
    end else begin
      rx_in = tx_pin_o;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      wait_s1 <= 1'b0;
      wait_s2 <= 1'b0;
    end else begin
      rx_s1 <= rx_pin_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      wait_s1 <= wait_mode_i;
      wait_s2 <= wait_s1;
    end
  end

  // baud tick
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      bcount <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!unit_on || baud == 16'h0000) begin
        bcount <= 16'h0000;
      end else if (bcount >= baud) begin
        bcount <= 16'h0000;
        tick <= 1'b1;
      end else begin
        bcount <= bcount + 16'h0001;
      end
    end
  end

  assign fr.len9 = frame_control[sfcs_pkg::BIT_LEN9];
  assign fr.par_en = frame_control[sfcs_pkg::BIT_PEN];
  assign fr.par_odd = frame_control[sfcs_pkg::BIT_PODD];
  assign fr.idle_type_select = frame_control[sfcs_pkg::BIT_ILT];
  assign fr.wake_mode = frame_control[sfcs_pkg::BIT_WAKE];
  assign fr.rx_on = control2[sfcs_pkg::BIT_RE] & unit_on;
  assign fr.rwu = control2[sfcs_pkg::BIT_RWU];
  assign fr.tick = tick;
  assign fr.rx_line = rx_in;

  sfcs_rx u_rx (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .fr(fr)
  );

  // transmitter: start, data, stop shifted lsb first
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      tx_shift <= 11'h7FF;
      tx_bits <= 4'h0;
      tx_tcnt <= 4'h0;
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      tx_full <= 1'b0;
      tx_hold <= 9'h000;
      tx_pin_o <= 1'b1;
      tx_pin_oe_o <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_pin_oe_o <= control2[sfcs_pkg::BIT_TE] & unit_on;
      if (wr && paddr == sfcs_pkg::ADDR_TX_DATA) begin
        tx_hold <= pwdata[8:0];
        tx_full <= 1'b1;
      end
      if (!control2[sfcs_pkg::BIT_TE] || !unit_on) begin
        tx_busy <= 1'b0;
        tx_pin_o <= 1'b1;
      end else if (!tx_busy && tx_full && tick) begin
        tx_shift <= {1'b1, parity_char(tx_hold, fr.len9, fr.par_en, fr.par_odd), 1'b0};
        tx_bits <= fr.len9 ? 4'hB : 4'hA;
        tx_tcnt <= 4'h0;
        tx_busy <= 1'b1;
        tx_full <= 1'b0;
      end else if (tx_busy && tick) begin
        tx_tcnt <= tx_tcnt + 4'h1;
        tx_pin_o <= tx_shift[0];
        if (tx_tcnt == sfcs_pkg::TICKS_PER_BIT) begin
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bits <= tx_bits - 4'h1;
          if (tx_bits == 4'h1) begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
            tx_pin_o <= 1'b1;
          end
        end
      end
    end
  end

  // event detection
  assign berr_tick = (alt_mode[2:1] == sfcs_pkg::BERR_T9) ? sfcs_pkg::TICK_9 : sfcs_pkg::TICK_13;
  assign berr_ev = tx_busy && tick && tx_tcnt == berr_tick && tx_tcnt != 4'h0
    && (alt_mode[2:1] == sfcs_pkg::BERR_T9 || alt_mode[2:1] == sfcs_pkg::BERR_T13)
    && (rx_s2 != tx_pin_o);
  assign edge_ev = (rx_s3 != rx_s2) && (rx_s2 == rx_polarity);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_edge_flag <= 1'b0;
      bit_error_flag <= 1'b0;
      bit_error_level <= 1'b0;
      break_flag <= 1'b0;
    end else begin
      if (edge_ev) begin
        rx_edge_flag <= 1'b1;
      end else if (wr && alt_map_select && paddr == sfcs_pkg::ADDR_ALT_STATUS && pwdata[sfcs_pkg::BIT_EDGE]) begin
        rx_edge_flag <= 1'b0;
      end
      if (berr_ev) begin
        bit_error_flag <= 1'b1;
        bit_error_level <= rx_s2;
      end else if (wr && alt_map_select && paddr == sfcs_pkg::ADDR_ALT_STATUS && pwdata[sfcs_pkg::BIT_BERR]) begin
        bit_error_flag <= 1'b0;
      end
      if (fr.rx_break && alt_mode[0]) begin
        break_flag <= 1'b1;
      end else if (wr && alt_map_select && paddr == sfcs_pkg::ADDR_ALT_STATUS && pwdata[sfcs_pkg::BIT_BRK]) begin
        break_flag <= 1'b0;
      end
    end
  end

  assign evt = {fr.rx_ferr, fr.rx_perr, tx_done, fr.rx_done, fr.rx_idle, edge_ev, berr_ev,
    fr.rx_break & alt_mode[0]};

  // sticky interrupt status, set wins over clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_status <= sfcs_pkg::RESET_BYTE;
    end else if (wr && paddr == sfcs_pkg::ADDR_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~pwdata[7:0]) | evt;
    end else begin
      irq_status <= irq_status | evt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_enable) | |({alt_control[sfcs_pkg::BIT_EDGE], alt_control[1:0]}
        & {rx_edge_flag, bit_error_flag, break_flag});
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rx_buf <= 9'h000;
    end else if (fr.rx_done) begin
      rx_buf <= fr.rx_data;
    end
  end

  // register writes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      frame_control <= sfcs_pkg::RESET_BYTE;
      alt_control <= sfcs_pkg::RESET_BYTE;
      alt_mode <= sfcs_pkg::RESET_BYTE;
      control2 <= sfcs_pkg::RESET_BYTE;
      alt_map_select <= 1'b0;
      rx_polarity <= 1'b0;
      irq_enable <= sfcs_pkg::RESET_BYTE;
      baud <= BAUD_DIV;
    end else begin
      if (fr.rx_wake || (fr.rx_idle && !fr.wake_mode)) begin
        control2[sfcs_pkg::BIT_RWU] <= 1'b0;
      end
      if (wr) begin
        if (paddr == sfcs_pkg::ADDR_FRAME_CONTROL && !alt_map_select) begin
          frame_control <= pwdata[7:0];
        end else if (paddr == sfcs_pkg::ADDR_ALT_CONTROL && alt_map_select) begin
          alt_control <= pwdata[7:0] & 8'h83;
        end else if (paddr == sfcs_pkg::ADDR_ALT_MODE && alt_map_select) begin
          alt_mode <= pwdata[7:0] & 8'h07;
        end else if (paddr == sfcs_pkg::ADDR_CONTROL2) begin
          control2 <= pwdata[7:0];
        end else if (paddr == sfcs_pkg::ADDR_STATUS2) begin
          alt_map_select <= pwdata[sfcs_pkg::BIT_MAP];
          rx_polarity <= pwdata[sfcs_pkg::BIT_RX_POLARITY];
        end else if (paddr == sfcs_pkg::ADDR_IRQ_ENABLE) begin
          irq_enable <= pwdata[7:0];
        end else if (paddr == sfcs_pkg::ADDR_BAUD) begin
          baud <= pwdata[15:0];
        end
      end
    end
  end

  // read mux, registered
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == sfcs_pkg::ADDR_ALT_STATUS && alt_map_select) begin
          prdata <= {24'h000000, rx_edge_flag, 4'h0, bit_error_level, bit_error_flag, break_flag};
        end else if (paddr == sfcs_pkg::ADDR_FRAME_CONTROL && !alt_map_select) begin
          prdata <= {24'h000000, frame_control};
        end else if (paddr == sfcs_pkg::ADDR_ALT_CONTROL && alt_map_select) begin
          prdata <= {24'h000000, alt_control};
        end else if (paddr == sfcs_pkg::ADDR_ALT_MODE && alt_map_select) begin
          prdata <= {24'h000000, alt_mode};
        end else if (paddr == sfcs_pkg::ADDR_CONTROL2) begin
          prdata <= {24'h000000, control2};
        end else if (paddr == sfcs_pkg::ADDR_STATUS2) begin
          prdata <= {24'h000000, alt_map_select, 3'h0, rx_polarity, 2'h0, tx_busy};
        end else if (paddr == sfcs_pkg::ADDR_RX_DATA) begin
          prdata <= {23'h000000, rx_buf};
        end else if (paddr == sfcs_pkg::ADDR_IRQ_STATUS) begin
          prdata <= {24'h000000, irq_status};
        end else if (paddr == sfcs_pkg::ADDR_IRQ_ENABLE) begin
          prdata <= {24'h000000, irq_enable};
        end else if (paddr == sfcs_pkg::ADDR_BAUD) begin
          prdata <= {16'h0000, baud};
        end else if (paddr == sfcs_pkg::ADDR_TX_DATA || paddr == sfcs_pkg::ADDR_IRQ_CLEAR) begin
          prdata <= 32'h0000_0000;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : sfcs_top
`default_nettype wire

/* File: testbench/sfcs_top_sva.sv */
/* Port checker for sfcs_top, bound to every instance.
   Assumes an APB master that keeps the two-cycle transfer. */
`timescale 1ns/1ps
`default_nettype none
module sfcs_top_sva (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wait_mode_i,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_o,
  input wire logic irq_o
);
  logic map_q;
  logic te_q;
  logic swai_q;
  wire logic acc = psel && penable && pready;
  wire logic run = te_q && !swai_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // shadow of map, transmitter enable and stop-in-wait bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      map_q <= 1'b0;
      te_q <= 1'b0;
      swai_q <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == sfcs_pkg::ADDR_STATUS2) map_q <= pwdata[7];
      if (paddr == sfcs_pkg::ADDR_CONTROL2) te_q <= pwdata[3];
      if (paddr == sfcs_pkg::ADDR_FRAME_CONTROL && !map_q) swai_q <= pwdata[6];
    end
  end
  property p_ready_next; psel && !penable |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_single; pready |=> !pready; endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready longer than one cycle");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_prdata_hold; !psel |=> $stable(prdata); endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved while idle");
  property p_gate_rd;
    acc && !pwrite && !map_q && (paddr == sfcs_pkg::ADDR_ALT_STATUS || paddr == sfcs_pkg::ADDR_ALT_CONTROL)
      |-> pslverr && prdata == 32'h0;
  endproperty
  a_gate_rd: assert property (p_gate_rd) else $error("alternative register read in main map");
  property p_wait_stop; swai_q && $past(swai_q, 4) && wait_mode_i && $past(wait_mode_i, 4) |-> !tx_pin_oe_o; endproperty
  a_wait_stop: assert property (p_wait_stop) else $error("unit runs in wait mode");
  property p_wait_run; run && $past(run, 4) |-> tx_pin_oe_o; endproperty
  a_wait_run: assert property (p_wait_run) else $error("transmitter stopped while enabled");
  property p_oe_idle; $rose(tx_pin_oe_o) |-> tx_pin_o; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("line not idle high on enable");
  c_alt_wr: cover property (acc && pwrite && map_q);
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (acc && pslverr);
endmodule : sfcs_top_sva
bind sfcs_top sfcs_top_sva sfcs_top_sva_inst (.ref_clk_i, .rst_b_i, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .wait_mode_i, .tx_pin_o, .tx_pin_oe_o, .irq_o);
`default_nettype wire

/* File: testbench/sfcs_node_model.sv */
/* Remote serial node: drives the line into the receive pin, sees tx.
   Assumes BIT_CLKS clocks per bit; the line idles high by pull-up. */
`timescale 1ns/1ps
`default_nettype none
module sfcs_node_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  input wire logic tx_pin_i,
  output logic rx_pin_o
);
  logic lvl = 1'b1;
  logic echo = 1'b0;
  // echo mirrors the transmitter, else own level
  assign rx_pin_o = echo ? tx_pin_i : lvl;
  task automatic put(input logic b);
    @(posedge clk_i) lvl <= b;
    repeat (BIT_CLKS - 1) @(posedge clk_i);
  endtask : put
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    put(stop);
    put(1'b1);
  endtask : send
endmodule : sfcs_node_model
`default_nettype wire

/* File: testbench/sfcs_top_tb_top.sv */
/* Testbench for sfcs_top: APB tasks, remote node, register scenarios.
   Assumes one-cycle pready and a tick every BAUD_DIV+1 clocks. */
`timescale 1ns/1ps
`default_nettype none
module sfcs_top_tb_top;
  localparam logic [15:0] DIV = 16'h0001;
  localparam int BITC = 16 * (DIV + 1);
  localparam logic [11:0] FC = sfcs_pkg::ADDR_FRAME_CONTROL;
  localparam logic [11:0] AS = sfcs_pkg::ADDR_ALT_STATUS;
  localparam logic [11:0] AC = sfcs_pkg::ADDR_ALT_CONTROL;
  localparam logic [11:0] AM = sfcs_pkg::ADDR_ALT_MODE;
  localparam logic [11:0] C2 = sfcs_pkg::ADDR_CONTROL2;
  localparam logic [11:0] S2 = sfcs_pkg::ADDR_STATUS2;
  localparam logic [11:0] TX = sfcs_pkg::ADDR_TX_DATA;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic wait_mode_i = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] msk;
  logic pready, pslverr, rx_pin, tx_pin_o, tx_pin_oe_o, irq_o, err, perr;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] fcs [0:5] = '{8'h00, 8'h10, 8'h02, 8'h02, 8'h03, 8'h03};
  logic [8:0] ds [0:5] = '{9'h0C3, 9'h1A5, 9'h003, 9'h083, 9'h083, 9'h003};
  sfcs_top #(.BAUD_DIV(DIV)) sfcs_top_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin_i(rx_pin), .wait_mode_i(wait_mode_i), .tx_pin_o(tx_pin_o),
    .tx_pin_oe_o(tx_pin_oe_o), .irq_o(irq_o));
  sfcs_node_model #(.BIT_CLKS(BITC)) sfcs_node_model_inst (.clk_i(ref_clk_i), .tx_pin_i(tx_pin_o),
    .rx_pin_o(rx_pin));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdc
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rdc(FC, 32'hFFFFFFFF, 32'h00);
    xfer(1'b0, AS, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(FC, 32'h5A);
    rdc(FC, 32'hFFFFFFFF, 32'h5A);
    wr(S2, 32'h80);
    rdc(AM, 32'hFFFFFFFF, 32'h0);
    wr(AM, 32'h3);
    rdc(AM, 32'h7, 32'h3);
    xfer(1'b0, 12'hFFC, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      wr(S2, p ? 32'h88 : 32'h80);
      wr(AS, 32'h87);
      sfcs_node_model_inst.put(1'b0);
      rdc(AS, 32'h80, p ? 32'h00 : 32'h80);
      wr(AS, 32'h00);
      sfcs_node_model_inst.put(1'b1);
      rdc(AS, 32'h80, 32'h80);
      wr(AS, 32'h80);
      rdc(AS, 32'h80, 32'h00);
    end
    // bit error: clean echo, then a line stuck low
    wr(S2, 32'h80);
    wr(AC, 32'h02);
    wr(C2, 32'h08);
    for (int k = 0; k < 3; k++) begin
      wr(AM, k[1] ? 32'h4 : 32'h2);
      wr(AS, 32'h86);
      sfcs_node_model_inst.echo <= !k;
      sfcs_node_model_inst.lvl <= 1'b0;
      wr(TX, 32'h55);
      repeat (12 * BITC) @(posedge ref_clk_i);
      rdc(AS, 32'h6, k ? 32'h2 : 32'h0);
      check({31'h0, irq_o}, {31'h0, k != 0});
    end
    sfcs_node_model_inst.lvl <= 1'b1;
    wr(AS, 32'h86);
    repeat (2) @(posedge ref_clk_i);
    check({31'h0, irq_o}, 32'h0);
    wr(S2, 32'h00);
    wr(FC, 32'h00);
    wait_mode_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    check({31'h0, tx_pin_oe_o}, 32'h1);
    wr(FC, 32'h40);
    repeat (6) @(posedge ref_clk_i);
    check({31'h0, tx_pin_oe_o}, 32'h0);
    wait_mode_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    check({31'h0, tx_pin_oe_o}, 32'h1);
    // loop and single-wire with the pin held low
    for (int s = 0; s < 2; s++) begin
      wr(FC, s ? 32'hA0 : 32'h80);
      sfcs_node_model_inst.lvl <= 1'b0;
      wr(C2, 32'h0C);
      wr(TX, s ? 32'h3C : 32'hA5);
      repeat (12 * BITC) @(posedge ref_clk_i);
      rdc(sfcs_pkg::ADDR_RX_DATA, 32'hFF, s ? 32'h3C : 32'hA5);
      rdc(sfcs_pkg::ADDR_IRQ_STATUS, 32'h80, 32'h0);
      sfcs_node_model_inst.lvl <= 1'b1;
      wr(C2, 32'h08);
    end
    wr(C2, 32'h04);
    for (int i = 0; i < 6; i++) begin
      wr(FC, {24'h0, fcs[i]});
      sfcs_node_model_inst.send(ds[i], fcs[i][4] ? 9 : 8, 1'b1);
      msk = fcs[i][1] ? 32'h7F : (fcs[i][4] ? 32'h1FF : 32'hFF);
      perr = fcs[i][1] && (ds[i][7] != (^ds[i][6:0] ^ fcs[i][0]));
      rdc(sfcs_pkg::ADDR_RX_DATA, msk, {23'h0, ds[i]} & msk);
      rdc(sfcs_pkg::ADDR_IRQ_STATUS, 32'h40, {25'h0, perr, 6'h0});
      wr(sfcs_pkg::ADDR_IRQ_CLEAR, 32'hFF);
    end
    wr(S2, 32'h80);
    wr(AC, 32'h01);
    for (int b = 0; b < 2; b++) begin
      wr(AM, b);
      wr(AS, 32'h87);
      sfcs_node_model_inst.send(9'h000, 8, 1'b0);
      rdc(AS, 32'h1, b);
      check({31'h0, irq_o}, b);
    end
    wr(AS, 32'h01);
    repeat (2) @(posedge ref_clk_i);
    check({31'h0, irq_o}, 32'h0);
    complete_run();
  end
endmodule : sfcs_top_tb_top
`default_nettype wire
